/* common/lfsds_pkg.sv */
// Constants, types and length decoders for the LF sampling duty scheduler.
// Assumes one system clock; oscillator timing arrives as ticks from the top module.
// What this block does
// R1: Control upper nibble is sampling interval; code 0000 means detector continuously on.
// R2: Interval codes 1 to 4 repeat sampling every 16, 32, 64, 128 periods.
// R3: Codes 5 to 8 give 256, 512, 1024, 2048 periods.
// R4: Writing the interval field starts a fresh interval at next oscillator tick.
// R5: Receiver reset loads the interval field with 0110.
// R6: Lower nibble sets detector on time at the start of each interval.
// R7: On time is net; up to 2 periods of init come from off time.
// R8: Carrier-detect mode powers detector down early once carrier evaluation completes.
// R9: Data mode keeps detector on after detection until end, error or timeout; the code ends the hold only on MESSAGE_DONE, disable or reset.
// R10: Reset clears the on-time field to zero, the shortest window.
// R11: On time spans 1 to 1024 oscillator periods.
// R12: On-time code n gives 2**n periods; codes above 10 are reserved.
// R13: Software changes control only while disabled; waits two periods before re-enabling.
// R14: Mode bit 0 selects data receive, 1 selects carrier detect.
// R15: Continuous mode restarts itself after a processed signal with 2-3 period gap; the code waits 2 oscillator ticks, 1 to 2 periods.
package lfsds_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] LFSDS_CTRL_ADDR = 8'h21;
	localparam logic [7:0] LFSDS_CTRL_RESET = 8'h60;
	localparam int LFSDS_SI_MSB = 7;
	localparam int LFSDS_SI_LSB = 4;
	localparam int LFSDS_ON_MSB = 3;
	localparam int LFSDS_ON_LSB = 0;
	localparam logic [3:0] LFSDS_SI_CONT = 4'h0;
	localparam logic [3:0] LFSDS_SI_MAX = 4'h8;
	localparam logic [3:0] LFSDS_ON_MAX = 4'hA;
	localparam logic [3:0] LFSDS_SI_SHIFT = 4'h3;

	// ==========================================================
	// Timing, in milliseconds and oscillator periods
	localparam int LFSDS_LFO_PERIOD_MS = 1;
	localparam int LFSDS_INIT_TIME_MS = 2;
	localparam logic [12:0] LFSDS_INIT_CYC = 13'(LFSDS_INIT_TIME_MS / LFSDS_LFO_PERIOD_MS);
	localparam logic [1:0] LFSDS_GAP_CYC = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONT, ST_GAP} lfsds_state_type;

	// ==========================================================
	// Decoders
	// Reserved interval codes fall back to the longest interval
	function automatic logic [12:0] lfsds_period_len(input logic [3:0] code);
		logic [3:0] c;
		c = (code > LFSDS_SI_MAX) ? LFSDS_SI_MAX : code;
		lfsds_period_len = 13'h0001 << (c + LFSDS_SI_SHIFT);
	endfunction : lfsds_period_len

	// R12 power of two on time
	function automatic logic [12:0] lfsds_on_len(input logic [3:0] code);
		logic [3:0] c;
		c = (code > LFSDS_ON_MAX) ? LFSDS_ON_MAX : code;
		lfsds_on_len = 13'h0001 << c;
	endfunction : lfsds_on_len
endpackage : lfsds_pkg

/* hw/lfsds_top.sv */
// Sampling scheduler: one control register, oscillator tick counting, detector power.
// Assumes register bus and receiver status inputs are on SYS_CLK; LFO_CLK is a pin.
`timescale 1ns/100ps
module lfsds_top (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic SOFT_RESET,
	input wire logic LFO_CLK,
	input wire logic [7:0] REG_ADDR,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [7:0] REG_WDATA,
	output logic [7:0] REG_RDATA,
	input wire logic RECEIVER_ENABLE,
	input wire logic CARRIER_DETECT_MODE,
	input wire logic SIGNAL_DETECTED,
	input wire logic CARRIER_EVAL_DONE,
	input wire logic MESSAGE_DONE,
	input wire logic SIGNAL_PROCESSED,
	output logic DETECTOR_POWER,
	output logic DETECTOR_WINDOW,
	output logic INTERVAL_START
);
	// ==========================================================
	// Oscillator synchroniser and tick
	logic lfo_s1_r;
	logic lfo_s2_r;
	logic lfo_s3_r;
	wire tick = lfo_s2_r & ~lfo_s3_r;

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			lfo_s1_r <= 1'b0;
			lfo_s2_r <= 1'b0;
			lfo_s3_r <= 1'b0;
		end
		else
		begin
			lfo_s1_r <= LFO_CLK;
			lfo_s2_r <= lfo_s1_r;
			lfo_s3_r <= lfo_s2_r;
		end
	end

	// ==========================================================
	// Control register
	logic [7:0] ctrl_r;
	logic [7:0] rdata_r;
	wire addr_hit = (REG_ADDR == lfsds_pkg::LFSDS_CTRL_ADDR);
	wire wr_hit = REG_WR & addr_hit;
	wire [7:0] rdata_nxt = (REG_RD & addr_hit) ? ctrl_r : 8'h00;
	wire [3:0] si_code = ctrl_r[lfsds_pkg::LFSDS_SI_MSB:lfsds_pkg::LFSDS_SI_LSB];
	wire [3:0] on_code = ctrl_r[lfsds_pkg::LFSDS_ON_MSB:lfsds_pkg::LFSDS_ON_LSB];

	// R5 R10 reset defaults
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N || SOFT_RESET)
			ctrl_r <= lfsds_pkg::LFSDS_CTRL_RESET;
		else if (wr_hit)
			ctrl_r <= REG_WDATA;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end

	// ==========================================================
	// Scheduler state
	lfsds_pkg::lfsds_state_type state_r;
	lfsds_pkg::lfsds_state_type state_nxt;
	logic [12:0] cnt_r;
	logic [12:0] cnt_nxt;
	logic [1:0] gap_r;
	logic [1:0] gap_nxt;
	logic start_r;
	logic early_off_r;
	logic hold_r;
	logic pwr_r;
	logic win_r;
	logic istart_r;

	// R2 R3 interval length
	wire [12:0] plen = lfsds_pkg::lfsds_period_len(si_code);
	// R6 R11 on-window length
	wire [12:0] olen = lfsds_pkg::lfsds_on_len(on_code);
	// R1 continuous selection
	wire cont_sel = (si_code == lfsds_pkg::LFSDS_SI_CONT);
	wire launch = tick & start_r & RECEIVER_ENABLE;
	wire wrap = (state_r == lfsds_pkg::ST_SAMPLE) & tick & ~start_r & (cnt_r == plen - 13'h0001);
	wire on_win = (state_r == lfsds_pkg::ST_SAMPLE) & (cnt_r < olen);
	// R7 init taken out of off time only
	wire init_win = (state_r == lfsds_pkg::ST_SAMPLE) & (cnt_r >= olen)
		& (cnt_r >= plen - lfsds_pkg::LFSDS_INIT_CYC);
	// R14 mode bit steers early off and hold
	wire data_mode = ~CARRIER_DETECT_MODE;
	// R8 early power down
	wire early_set = on_win & CARRIER_DETECT_MODE & CARRIER_EVAL_DONE;
	// R9 extended on time
	wire hold_set = on_win & data_mode & SIGNAL_DETECTED;
	wire pwr_nxt = RECEIVER_ENABLE & ((state_r == lfsds_pkg::ST_CONT)
		| (on_win & ~early_off_r) | hold_r | init_win);
	wire win_nxt = RECEIVER_ENABLE & ((state_r == lfsds_pkg::ST_CONT)
		| (on_win & ~early_off_r) | hold_r);

	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		gap_nxt = gap_r;
		case (state_r)
			lfsds_pkg::ST_IDLE:
			begin
				cnt_nxt = 13'h0000;
			end
			lfsds_pkg::ST_SAMPLE:
			begin
				if (tick)
					cnt_nxt = wrap ? 13'h0000 : cnt_r + 13'h0001;
			end
			lfsds_pkg::ST_CONT:
			begin
				// R15 self restart after processing
				if (SIGNAL_PROCESSED)
				begin
					state_nxt = lfsds_pkg::ST_GAP;
					gap_nxt = 2'h0;
				end
			end
			lfsds_pkg::ST_GAP:
			begin
				if (tick && gap_r == lfsds_pkg::LFSDS_GAP_CYC - 2'h1)
					state_nxt = lfsds_pkg::ST_CONT;
				else if (tick)
					gap_nxt = gap_r + 2'h1;
			end
			default:
			begin
				state_nxt = lfsds_pkg::ST_IDLE;
			end
		endcase
		// R4 fresh interval on the tick after a write or enable
		if (launch)
		begin
			state_nxt = cont_sel ? lfsds_pkg::ST_CONT : lfsds_pkg::ST_SAMPLE;
			cnt_nxt = 13'h0000;
		end
		if (!RECEIVER_ENABLE)
			state_nxt = lfsds_pkg::ST_IDLE;
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N || SOFT_RESET)
		begin
			state_r <= lfsds_pkg::ST_IDLE;
			cnt_r <= 13'h0000;
			gap_r <= 2'h0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			gap_r <= gap_nxt;
		end
	end

	// A write re-arms the interval; leaving enable also re-arms so restart waits a tick
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N || SOFT_RESET)
			start_r <= 1'b1;
		else if (wr_hit || !RECEIVER_ENABLE)
			start_r <= 1'b1;
		else if (launch)
			start_r <= 1'b0;
	end

	// Set wins over the interval-boundary clear
	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N || SOFT_RESET || !RECEIVER_ENABLE)
		begin
			early_off_r <= 1'b0;
			hold_r <= 1'b0;
		end
		else
		begin
			early_off_r <= early_set | (early_off_r & ~wrap & ~launch);
			hold_r <= hold_set | (hold_r & ~MESSAGE_DONE);
		end
	end

	always_ff @(posedge SYS_CLK)
	begin
		if (!RST_N)
		begin
			pwr_r <= 1'b0;
			win_r <= 1'b0;
			istart_r <= 1'b0;
		end
		else
		begin
			pwr_r <= pwr_nxt;
			win_r <= win_nxt;
			istart_r <= wrap | launch;
		end
	end

	assign REG_RDATA = rdata_r;
	assign DETECTOR_POWER = pwr_r;
	assign DETECTOR_WINDOW = win_r;
	assign INTERVAL_START = istart_r;

	// ==========================================================
	// Checks
	a_reset_defaults: assert property (@(posedge SYS_CLK) // R5 R10
		!RST_N || SOFT_RESET |=> ctrl_r == lfsds_pkg::LFSDS_CTRL_RESET)
		else $error("control reset value wrong");
	a_interval_wrap: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R2 R3
		wrap && RECEIVER_ENABLE && !SOFT_RESET |=> cnt_r == 13'h0000 && INTERVAL_START)
		else $error("interval did not wrap at its length");
	a_write_restart: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R4
		launch && !SOFT_RESET && !wr_hit |=> cnt_r == 13'h0000 && !start_r)
		else $error("interval not restarted at tick");
	a_cont_power: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R1
		state_r == lfsds_pkg::ST_CONT && RECEIVER_ENABLE |=> DETECTOR_POWER)
		else $error("continuous mode detector off");
	a_on_window: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R6
		on_win && !early_off_r && RECEIVER_ENABLE |=> DETECTOR_POWER && DETECTOR_WINDOW)
		else $error("on window not powered");
	a_early_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R8
		early_off_r && !hold_r && !init_win |=> !DETECTOR_POWER)
		else $error("detector not powered down early");
	a_hold_power: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R9
		hold_set && RECEIVER_ENABLE && !SOFT_RESET ##1 RECEIVER_ENABLE |=> DETECTOR_POWER)
		else $error("detector dropped during message");
	a_gap_off: assert property (@(posedge SYS_CLK) disable iff (!RST_N) // R15
		state_r == lfsds_pkg::ST_GAP |=> !DETECTOR_POWER)
		else $error("detector powered in restart gap");
endmodule : lfsds_top

/* bench/lfsds_top_tb.sv */
// Testbench for the sampling duty scheduler: register, interval, on-time and mode checks.
// Assumes lfsds_top alone; LFO_CLK is made here at exactly 16 system clocks per period.
`timescale 1ns/100ps
module lfsds_top_tb;
	logic clk = 0, rst_n = 0, srst = 0, low_freq_oscillator = 0, wr = 0, rd = 0, en = 0, cmode = 0;
	logic sdet = 0, cdone = 0, mdone = 0, sproc = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
	logic pwr, win, istart;
	int fail_count = 0, n_checks = 0;

	lfsds_top dut (.SYS_CLK(clk), .RST_N(rst_n), .SOFT_RESET(srst), .LFO_CLK(low_freq_oscillator),
		.REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.RECEIVER_ENABLE(en), .CARRIER_DETECT_MODE(cmode), .SIGNAL_DETECTED(sdet),
		.CARRIER_EVAL_DONE(cdone), .MESSAGE_DONE(mdone), .SIGNAL_PROCESSED(sproc),
		.DETECTOR_POWER(pwr), .DETECTOR_WINDOW(win), .INTERVAL_START(istart));

	initial forever #2 clk = ~clk;
	// Whole number of system clocks per tick keeps cycle counts exact
	initial forever #32 low_freq_oscillator = ~low_freq_oscillator;

	// ==========================================================
	// Shared tasks
	task automatic chk(string n, logic [15:0] g, logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_reg

	task automatic rd_reg(logic [7:0] a);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		v = rdata;
	endtask : rd_reg

	// One-hot select: 10 soft reset, 08 processed, 04 carrier done, 02 detected, 01 message done
	task automatic pulse(logic [4:0] m);
		@(negedge clk);
		{srst, sproc, cdone, sdet, mdone} = m;
		@(negedge clk);
		{srst, sproc, cdone, sdet, mdone} = 5'h00;
	endtask : pulse

	task automatic cyc(int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// reconfigure only while disabled, then 40 idle system clocks, two and a half oscillator periods
	task automatic setup(logic [7:0] c);
		en = 1'b0;
		cyc(40);
		wr_reg(8'h21, c);
		cyc(40);
		en = 1'b1;
	endtask : setup

	task automatic wait_start;
		for (int i = 0; i < 9000 && istart !== 1'b1; i++)
			@(negedge clk);
	endtask : wait_start

	task automatic wrap_up;
		if (fail_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		rd_reg(8'h21);
		chk("ctrl_rst", v, 8'h60);
		wr_reg(8'h20, 8'hFF);
		rd_reg(8'h20);
		chk("unmapped", v, 8'h00);
		wr_reg(8'h21, 8'hA5);
		rd_reg(8'h21);
		chk("ctrl_rw", v, 8'hA5);
		pulse(5'h10);
		rd_reg(8'h21);
		chk("soft_rst", v, 8'h60);
	endtask : t_regs

	// Counts one whole interval; init adds two ticks of power ahead of the next window
	task automatic measure(logic [7:0] c, int len, int on);
		int n = 0, w = 0, p = 0;
		setup(c);
		wait_start();
		do
		begin
			@(negedge clk);
			n++;
			w += (win === 1'b1) ? 1 : 0;
			p += (pwr === 1'b1) ? 1 : 0;
		end while (istart !== 1'b1 && n < 9000);
		chk("period", 16'(n), 16'(len));
		chk("window", 16'(w), 16'(on));
		chk("power", 16'(p), 16'(on + 32));
	endtask : measure

	task automatic t_modes;
		setup(8'h05);
		cyc(80);
		chk("cont_on", 16'(pwr), 16'h0001);
		pulse(5'h08);
		cyc(3);
		chk("gap_off", 16'(pwr), 16'h0000);
		cyc(80);
		chk("gap_back", 16'(pwr), 16'h0001);
		cmode = 1'b1;
		setup(8'h13);
		wait_start();
		cyc(20);
		pulse(5'h04);
		cyc(3);
		chk("early_off", 16'({pwr, win}), 16'h0000);
		cmode = 1'b0;
		setup(8'h10);
		wait_start();
		cyc(4);
		pulse(5'h02);
		cyc(40);
		chk("hold_on", 16'(pwr), 16'h0001);
		pulse(5'h01);
		cyc(3);
		chk("hold_end", 16'(pwr), 16'h0000);
	endtask : t_modes

	initial
	begin
		cyc(10);
		rst_n = 1'b1;
		t_regs();
		measure(8'h10, 256, 16);
		measure(8'h23, 512, 128);
		measure(8'h35, 1024, 512);
		measure(8'h54, 4096, 256);
		t_modes();
		wrap_up();
	end

	initial
	begin
		repeat (30000) @(posedge clk);
		fail_count++;
		wrap_up();
	end
endmodule : lfsds_top_tb
